// ---- core/ctb_bridge.v ----
// top of the two-port cut-through bridge with checksum generators
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ctb_map.vh"

// =============================================================
// serial checksum generator
module ctb_crc (
    input wire clk,
    input wire srst,
    input wire feedEn,
    input wire feedBit,
    input wire clear,
    output wire [31:0] crcValue
);
    reg [31:0] crc;
    wire [31:0] base = clear ? `CTB_CRC_INIT : crc;
    wire feedback = base[31] ^ feedBit;

    assign crcValue = ~crc;

    always @(posedge clk) begin
        if (srst) begin
            crc <= `CTB_CRC_INIT;
        end else if (feedEn) begin
            crc <= {base[30:0], 1'b0} ^
                (feedback ? `CTB_CRC_POLY : 32'h00000000);
        end
    end
endmodule

// =============================================================
// bridge top
module ctb_bridge (
    // clock and reset
    input wire clk,
    input wire srst,
    // register bus
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // port a
    input wire lineTxClockA,
    input wire recoveredRxClockA,
    input wire rxDataA,
    input wire carrierSenseNA,
    input wire collisionA,
    output wire lineTxDataA,
    output wire lineTxEnableA,
    // port b
    input wire lineTxClockB,
    input wire recoveredRxClockB,
    input wire rxDataB,
    input wire carrierSenseNB,
    input wire collisionB,
    output wire lineTxDataB,
    output wire lineTxEnableB
);
    localparam NP = `CTB_PIN_COUNT;

    // =========================================================
    // pin synchronisers and edge finding
    reg [NP-1:0] s1;
    reg [NP-1:0] s2;
    reg [NP-1:0] s3;
    reg [NP-1:0] filt;
    integer i;

    wire [NP-1:0] pins = {collisionB, collisionA,
        carrierSenseNB, carrierSenseNA, rxDataB, rxDataA,
        recoveredRxClockB, recoveredRxClockA, lineTxClockB, lineTxClockA};
    wire [NP-1:0] rise = (~(s2 ^ s3)) & s3 & ~filt;

    always @(posedge clk) begin
        if (srst) begin
            s1 <= `CTB_PIN_RST;
            s2 <= `CTB_PIN_RST;
            s3 <= `CTB_PIN_RST;
            filt <= `CTB_PIN_RST;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            for (i = 0; i < NP; i = i + 1) begin
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end

    wire txTickA = rise[`CTB_PIN_TXC];
    wire txTickB = rise[`CTB_PIN_TXC + 1];
    wire rxTickA = rise[`CTB_PIN_RXC];
    wire rxTickB = rise[`CTB_PIN_RXC + 1];

    // =========================================================
    // control registers
    reg [1:0] ctrl;
    reg [7:0] key;
    reg [15:0] framesA;
    reg [15:0] framesB;
    reg [15:0] aborts;

    wire encEnable = ctrl[`CTB_CTRL_ENC];
    wire crcEnable = ctrl[`CTB_CTRL_CRC];

    // =========================================================
    // receivers
    wire recvDataA;
    wire recvFrameA;
    wire recvPayloadA;
    wire [2:0] recvIdxA;
    wire recvAbortA;
    wire recvStartA;
    wire recvDataB;
    wire recvFrameB;
    wire recvPayloadB;
    wire [2:0] recvIdxB;
    wire recvAbortB;
    wire recvStartB;

    ctb_rx rxA (
        .clk(clk),
        .srst(srst),
        .bitTick(rxTickA),
        .rxBit(filt[`CTB_PIN_RXD]),
        .carrierSenseN(filt[`CTB_PIN_CRS]),
        .collision(filt[`CTB_PIN_COL]),
        .keepRxCrc(~crcEnable),
        .recvData(recvDataA),
        .recvFrame(recvFrameA),
        .recvPayload(recvPayloadA),
        .recvBitIdx(recvIdxA),
        .recvAbort(recvAbortA),
        .recvStart(recvStartA)
    );

    ctb_rx rxB (
        .clk(clk),
        .srst(srst),
        .bitTick(rxTickB),
        .rxBit(filt[`CTB_PIN_RXD + 1]),
        .carrierSenseN(filt[`CTB_PIN_CRS + 1]),
        .collision(filt[`CTB_PIN_COL + 1]),
        .keepRxCrc(~crcEnable),
        .recvData(recvDataB),
        .recvFrame(recvFrameB),
        .recvPayload(recvPayloadB),
        .recvBitIdx(recvIdxB),
        .recvAbort(recvAbortB),
        .recvStart(recvStartB)
    );

    // =========================================================
    // payload cipher, each port feeds the opposite transmitter
    wire sendToB = recvDataA ^
        (encEnable & recvPayloadA & key[recvIdxA]);
    wire sendToA = recvDataB ^
        (encEnable & recvPayloadB & key[recvIdxB]);

    // =========================================================
    // checksum generators and transmitters
    wire [31:0] crcA;
    wire [31:0] crcB;
    wire feedBitA;
    wire feedEnA;
    wire clearA;
    wire feedBitB;
    wire feedEnB;
    wire clearB;

    ctb_crc crcGenA (
        .clk(clk),
        .srst(srst),
        .feedEn(feedEnA),
        .feedBit(feedBitA),
        .clear(clearA),
        .crcValue(crcA)
    );

    ctb_crc crcGenB (
        .clk(clk),
        .srst(srst),
        .feedEn(feedEnB),
        .feedBit(feedBitB),
        .clear(clearB),
        .crcValue(crcB)
    );

    ctb_tx txA (
        .clk(clk),
        .srst(srst),
        .bitTick(txTickA),
        .sendData(sendToA),
        .sendFrame(recvFrameB),
        .abort(recvAbortB),
        .crcEnable(crcEnable),
        .crcValue(crcA),
        .lineTxData(lineTxDataA),
        .lineTxEnable(lineTxEnableA),
        .crcFeedBit(feedBitA),
        .crcFeedEn(feedEnA),
        .crcClear(clearA)
    );

    ctb_tx txB (
        .clk(clk),
        .srst(srst),
        .bitTick(txTickB),
        .sendData(sendToB),
        .sendFrame(recvFrameA),
        .abort(recvAbortA),
        .crcEnable(crcEnable),
        .crcValue(crcB),
        .lineTxData(lineTxDataB),
        .lineTxEnable(lineTxEnableB),
        .crcFeedBit(feedBitB),
        .crcFeedEn(feedEnB),
        .crcClear(clearB)
    );

    // =========================================================
    // event counters
    always @(posedge clk) begin
        if (srst) begin
            framesA <= `CTB_CNT_RST;
            framesB <= `CTB_CNT_RST;
            aborts <= `CTB_CNT_RST;
        end else begin
            framesA <= framesA + {15'h0000, recvStartA};
            framesB <= framesB + {15'h0000, recvStartB};
            aborts <= aborts + {15'h0000, recvAbortA} +
                {15'h0000, recvAbortB};
        end
    end

    // =========================================================
    // register bus slave
    reg [7:0] awAddr;
    reg awHeld;
    reg [31:0] wData;
    reg [3:0] wStrb;
    reg wHeld;
    reg [31:0] readValue;
    reg readHit;

    always @* begin
        readValue = 32'h00000000;
        readHit = 1'b1;
        case (araddr)
            `CTB_REG_CTRL: readValue = {30'h00000000, ctrl};
            `CTB_REG_KEY: readValue = {24'h000000, key};
            `CTB_REG_STATUS: readValue = {28'h0000000, lineTxEnableB,
                lineTxEnableA, recvFrameB, recvFrameA};
            `CTB_REG_FRAMES_A: readValue = {16'h0000, framesA};
            `CTB_REG_FRAMES_B: readValue = {16'h0000, framesB};
            `CTB_REG_ABORTS: readValue = {16'h0000, aborts};
            default: readHit = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `CTB_RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `CTB_RESP_OKAY;
            rdata <= 32'h00000000;
            awAddr <= 8'h00;
            awHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            wHeld <= 1'b0;
            ctrl <= `CTB_CTRL_RST;
            key <= `CTB_KEY_RST;
        end else begin
            if (awvalid && awready) begin
                awAddr <= awaddr;
                awHeld <= 1'b1;
                awready <= 1'b0;
            end else begin
                awready <= !awHeld && !bvalid;
            end
            if (wvalid && wready) begin
                wData <= wdata;
                wStrb <= wstrb;
                wHeld <= 1'b1;
                wready <= 1'b0;
            end else begin
                wready <= !wHeld && !bvalid;
            end
            if (awHeld && wHeld && !bvalid) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `CTB_RESP_OKAY;
                if (awAddr == `CTB_REG_CTRL) begin
                    if (wStrb[0]) begin
                        ctrl <= wData[1:0];
                    end
                end else if (awAddr == `CTB_REG_KEY) begin
                    if (wStrb[0]) begin
                        key <= wData[7:0];
                    end
                end else if (awAddr != `CTB_REG_STATUS &&
                    awAddr != `CTB_REG_FRAMES_A &&
                    awAddr != `CTB_REG_FRAMES_B &&
                    awAddr != `CTB_REG_ABORTS) begin
                    bresp <= `CTB_RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= readValue;
                rresp <= readHit ? `CTB_RESP_OKAY : `CTB_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else begin
                arready <= !rvalid;
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/ctb_map.vh ----
// constants and register map of the cut-through ethernet port bridge
// Behaviour
// - receive logic runs on recovered receive clock edges
// - receiver flags payload bits for encryption
// - transmitter emits 802.3 frames, cut short when the source port sees a collision
// - no frame store; abandon frame on collision
// - 64-bit buffer preloaded with preamble and delimiter
// - buffer carries checksum; send 32 bits after payload
// - port to port delay is 72 bit times
// - forward every bit even while opposite port receives
// - always regenerate full standard-length preamble
// - checksum generation off; received checksum carried encrypted
// - payload bytes XORed with key byte
// - receiver ports: collision, carrier, data, clock in
// - transmitter ports: clock, stream, checksum in; data, enable
// - checksum generator reads outgoing serial stream
// - two receivers, transmitters, checksum generators
// - transmit enable high while sending serial data
// - receiver starts frame at the delimiter that follows the preamble once carrier is sensed
`ifndef CTB_MAP_VH
`define CTB_MAP_VH

// frame layout, in bits and bytes
`define CTB_TX_BUF_BITS 64
`define CTB_LATENCY_BITS 72
`define CTB_STAGE_BITS (`CTB_LATENCY_BITS - `CTB_TX_BUF_BITS)
`define CTB_HDR_BITS 14'd96
`define CTB_LEN_BITS 14'd16
`define CTB_CRC_BITS 14'd32
`define CTB_MIN_PAY_BYTES 11'd48
`define CTB_MAX_LENGTH 16'd1500
`define CTB_SFD_PATTERN 8'hab
`define CTB_TX_PRELOAD 64'haaaaaaaaaaaaaaab
`define CTB_CRC_POLY 32'h04c11db7
`define CTB_CRC_INIT 32'hffffffff

// pin sampling: bit order of the synchroniser vector
`define CTB_PIN_COUNT 10
`define CTB_PIN_TXC 0
`define CTB_PIN_RXC 2
`define CTB_PIN_RXD 4
`define CTB_PIN_CRS 6
`define CTB_PIN_COL 8
`define CTB_PIN_RST 10'h0c0

// register map, byte addresses
`define CTB_REG_CTRL 8'h00
`define CTB_REG_KEY 8'h04
`define CTB_REG_STATUS 8'h08
`define CTB_REG_FRAMES_A 8'h0c
`define CTB_REG_FRAMES_B 8'h10
`define CTB_REG_ABORTS 8'h14
`define CTB_CTRL_ENC 0
`define CTB_CTRL_CRC 1
`define CTB_CTRL_RST 2'b01
`define CTB_KEY_RST 8'h00
`define CTB_CNT_RST 16'h0000
`define CTB_RESP_OKAY 2'b00
`define CTB_RESP_SLVERR 2'b10

`endif

// ---- core/ctb_rx.v ----
// serial receive interface: frame and payload marking
`timescale 1ns/1ps
`default_nettype none
`include "ctb_map.vh"
module ctb_rx (
    // clock and reset
    input wire clk,
    input wire srst,
    // sampled line side
    input wire bitTick,
    input wire rxBit,
    input wire carrierSenseN,
    input wire collision,
    input wire keepRxCrc,
    // marked stream
    output reg recvData,
    output reg recvFrame,
    output reg recvPayload,
    output reg [2:0] recvBitIdx,
    output reg recvAbort,
    output reg recvStart
);
    localparam IDLE = 3'd0;
    localparam PRE = 3'd1;
    localparam HDR = 3'd2;
    localparam LEN = 3'd3;
    localparam PAY = 3'd4;
    localparam TAIL = 3'd5;

    reg [2:0] state;
    reg [13:0] cnt;
    reg [7:0] preSh;
    reg [15:0] lenSh;
    reg [2:0] payIdx;
    reg untilCarrier;

    // =========================================================
    // length decode
    wire [15:0] nextLen = {rxBit, lenSh[15:1]};
    wire [15:0] lenVal = {nextLen[7:0], nextLen[15:8]};
    wire [10:0] payBytes = (lenVal < {5'h00, `CTB_MIN_PAY_BYTES}) ?
        `CTB_MIN_PAY_BYTES : lenVal[10:0];
    wire [13:0] payBits = {payBytes, 3'b000} +
        (keepRxCrc ? `CTB_CRC_BITS : 14'd0) - 14'd1;
    wire inFrame = (state == HDR) || (state == LEN) || (state == PAY);
    wire [7:0] nextPre = {preSh[6:0], rxBit};

    // =========================================================
    // receive sequence
    always @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
            cnt <= 14'd0;
            preSh <= 8'h00;
            lenSh <= 16'h0000;
            payIdx <= 3'd0;
            untilCarrier <= 1'b0;
            recvData <= 1'b0;
            recvFrame <= 1'b0;
            recvPayload <= 1'b0;
            recvBitIdx <= 3'd0;
            recvAbort <= 1'b0;
            recvStart <= 1'b0;
        end else begin
            recvAbort <= 1'b0;
            recvStart <= 1'b0;
            if (carrierSenseN) begin
                state <= IDLE;
                recvFrame <= 1'b0;
                recvPayload <= 1'b0;
            end else if (collision && state != IDLE && state != TAIL) begin
                state <= TAIL;
                recvFrame <= 1'b0;
                recvPayload <= 1'b0;
                recvAbort <= (state != PRE);
            end else if (bitTick) begin
                recvData <= rxBit;
                recvFrame <= inFrame;
                recvPayload <= (state == PAY);
                recvBitIdx <= (state == PAY) ? payIdx : 3'd0;
                case (state)
                    IDLE: begin
                        state <= PRE;
                        preSh <= {7'h00, rxBit};
                    end
                    PRE: begin
                        preSh <= nextPre;
                        if (nextPre == `CTB_SFD_PATTERN) begin
                            state <= HDR;
                            cnt <= `CTB_HDR_BITS - 14'd1;
                            recvStart <= 1'b1;
                        end
                    end
                    HDR: begin
                        if (cnt == 14'd0) begin
                            state <= LEN;
                            cnt <= `CTB_LEN_BITS - 14'd1;
                        end else begin
                            cnt <= cnt - 14'd1;
                        end
                    end
                    LEN: begin
                        lenSh <= nextLen;
                        if (cnt == 14'd0) begin
                            state <= PAY;
                            cnt <= payBits;
                            payIdx <= 3'd0;
                            untilCarrier <= (lenVal > `CTB_MAX_LENGTH);
                        end else begin
                            cnt <= cnt - 14'd1;
                        end
                    end
                    PAY: begin
                        payIdx <= payIdx + 3'd1;
                        if (!untilCarrier) begin
                            if (cnt == 14'd0) begin
                                state <= TAIL;
                            end else begin
                                cnt <= cnt - 14'd1;
                            end
                        end
                    end
                    TAIL: begin
                        state <= TAIL;
                    end
                    default: begin
                        state <= IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/ctb_tx.v ----
// serial transmit interface with preamble and checksum buffer
`timescale 1ns/1ps
`default_nettype none
`include "ctb_map.vh"
module ctb_tx (
    // clock and reset
    input wire clk,
    input wire srst,
    // outgoing stream
    input wire bitTick,
    input wire sendData,
    input wire sendFrame,
    input wire abort,
    input wire crcEnable,
    input wire [31:0] crcValue,
    // line side
    output reg lineTxData,
    output reg lineTxEnable,
    // checksum feed
    output wire crcFeedBit,
    output wire crcFeedEn,
    output wire crcClear
);
    localparam IDLE = 2'd0;
    localparam SEND = 2'd1;
    localparam CRC = 2'd2;
    localparam DRAIN = 2'd3;
    localparam ST = `CTB_STAGE_BITS;
    localparam BB = `CTB_TX_BUF_BITS;

    reg [1:0] state;
    reg [5:0] cnt;
    reg [ST-1:0] stData;
    reg [ST-1:0] stFrame;
    reg [BB-1:0] buffer;

    wire inBit = stData[ST-1];
    wire inFrame = stFrame[ST-1];

    // checksum sees the stream entering the buffer
    assign crcFeedBit = inBit;
    assign crcFeedEn = bitTick && inFrame &&
        (state == IDLE || state == SEND);
    assign crcClear = bitTick && inFrame && state == IDLE;

    // =========================================================
    // alignment stage and delay buffer
    always @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
            cnt <= 6'd0;
            stData <= {ST{1'b0}};
            stFrame <= {ST{1'b0}};
            buffer <= `CTB_TX_PRELOAD;
            lineTxData <= 1'b0;
            lineTxEnable <= 1'b0;
        end else if (abort) begin
            state <= IDLE;
            stFrame <= {ST{1'b0}};
            buffer <= `CTB_TX_PRELOAD;
            lineTxData <= 1'b0;
            lineTxEnable <= 1'b0;
        end else if (bitTick) begin
            stData <= {stData[ST-2:0], sendData};
            stFrame <= {stFrame[ST-2:0], sendFrame};
            case (state)
                IDLE: begin
                    if (inFrame) begin
                        state <= SEND;
                        lineTxData <= buffer[BB-1];
                        lineTxEnable <= 1'b1;
                        buffer <= {buffer[BB-2:0], inBit};
                    end else begin
                        lineTxData <= 1'b0;
                        lineTxEnable <= 1'b0;
                        buffer <= `CTB_TX_PRELOAD;
                    end
                end
                SEND: begin
                    lineTxData <= buffer[BB-1];
                    if (inFrame) begin
                        buffer <= {buffer[BB-2:0], inBit};
                    end else if (crcEnable) begin
                        buffer <= {buffer[BB-2:0], crcValue[31]};
                        cnt <= 6'd30;
                        state <= CRC;
                    end else begin
                        buffer <= {buffer[BB-2:0], 1'b0};
                        cnt <= 6'd62;
                        state <= DRAIN;
                    end
                end
                CRC: begin
                    lineTxData <= buffer[BB-1];
                    buffer <= {buffer[BB-2:0], crcValue[cnt[4:0]]};
                    if (cnt == 6'd0) begin
                        cnt <= 6'd63;
                        state <= DRAIN;
                    end else begin
                        cnt <= cnt - 6'd1;
                    end
                end
                DRAIN: begin
                    lineTxData <= buffer[BB-1];
                    buffer <= {buffer[BB-2:0], 1'b0};
                    if (cnt == 6'd0) begin
                        state <= IDLE;
                    end else begin
                        cnt <= cnt - 6'd1;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verif/ctb_bridge_chk.sv ----
// assertions on the bridge ports
`timescale 1ns/1ps
`default_nettype none
module ctb_bridge_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire logic awready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic carrierSenseNB,
    input wire logic collisionA,
    input wire logic lineTxEnableA,
    input wire logic lineTxEnableB
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_colHeld; collisionA [*8]; endsequence
    sequence s_startB; $rose(lineTxEnableB); endsequence
    property p_bHold; bvalid && !bready |=> bvalid; endproperty
    property p_rHold; rvalid && !rready |=> rvalid; endproperty
    property p_wBusy; bvalid |-> !awready; endproperty
    property p_rBusy; rvalid |-> !arready; endproperty
    property p_drop; s_colHeld |-> !lineTxEnableB; endproperty
    property p_fwd; $rose(lineTxEnableA) |-> !carrierSenseNB; endproperty
    property p_preB; s_startB |-> ##300 lineTxEnableB; endproperty
    property p_preA; $rose(lineTxEnableA) |-> ##300 lineTxEnableA; endproperty
    a_bHold: assert property (p_bHold) else $error("bvalid dropped");
    a_rHold: assert property (p_rHold) else $error("rvalid dropped");
    a_wBusy: assert property (p_wBusy) else $error("awready too early");
    a_rBusy: assert property (p_rBusy) else $error("arready too early");
    a_drop: assert property (p_drop) else $error("kept frame");
    a_fwd: assert property (p_fwd) else $error("no carrier");
    a_preB: assert property (p_preB) else $error("short B");
    a_preA: assert property (p_preA) else $error("short A");
endmodule
bind ctb_bridge ctb_bridge_chk u_chk (.*);
`default_nettype wire

// ---- verif/ctb_bridge_tb.sv ----
// bench of the two-port bridge
`timescale 1ns/1ps
`default_nettype none
`include "ctb_map.vh"
module ctb_bridge_tb;
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, key;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic tcA, rcA, rdA, csA, coA, tdA, teA;
    logic tcB, rcB, rdB, csB, coB, tdB, teB;
    logic qA[$], qB[$];
    realtime tEnB;
    int err_count, check_count, cyc;
    ctb_bridge u_dut (.*, .wstrb(4'hf), .lineTxClockA(tcA),
        .recoveredRxClockA(rcA),
        .rxDataA(rdA), .carrierSenseNA(csA), .collisionA(coA),
        .lineTxDataA(tdA), .lineTxEnableA(teA), .lineTxClockB(tcB),
        .recoveredRxClockB(rcB), .rxDataB(rdB), .carrierSenseNB(csB),
        .collisionB(coB), .lineTxDataB(tdB), .lineTxEnableB(teB));
    ctb_xcvr #(.OFS(13)) u_phyA (.txClk(tcA), .rxClk(rcA), .rxData(rdA),
        .crsN(csA), .col(coA));
    ctb_xcvr #(.OFS(51)) u_phyB (.txClk(tcB), .rxClk(rcB), .rxData(rdB),
        .crsN(csB), .col(coB));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge tcA)
        if (teA === 1'b1) qA.push_back(tdA);
    always @(posedge tcB)
        if (teB === 1'b1) qB.push_back(tdB);
    always @(posedge teB)
        tEnB = $realtime;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, `CTB_RESP_OKAY);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, r);
    endtask
    task automatic build(ref logic [7:0] q[$], input int len);
        q.delete();
        repeat (12) q.push_back(8'($urandom));
        q.push_back(len[15:8]);
        q.push_back(len[7:0]);
        repeat (len + 4) q.push_back(8'($urandom));
    endtask
    function automatic logic expBit(logic [7:0] b, int i, logic enc);
        return b[i % 8] ^ (enc & (i >= 112) & key[i % 8]);
    endfunction
    task automatic chkFrame(logic c[$], logic [7:0] f[$], logic enc);
        chk(c.size(), 64 + 8 * f.size());
        if (c.size() < 64 + 8 * f.size()) return;
        for (int i = 0; i < 64; i++)
            chk(c[i], 1'(`CTB_TX_PRELOAD >> (63 - i)));
        for (int i = 0; i < 8 * f.size(); i++)
            chk(c[64 + i], expBit(f[i / 8], i, enc));
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, cyc, err_count, check_count} = 0;
        void'($urandom(87955));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(`CTB_REG_CTRL, 32'h1, `CTB_RESP_OKAY);
        rd(`CTB_REG_KEY, 32'h0, `CTB_RESP_OKAY);
        rd(8'hfc, 32'h0, `CTB_RESP_SLVERR);
        $display("test registers done");
        for (int t = 0; t < 3; t++) begin
            key = 8'($urandom);
            wr(`CTB_REG_KEY, {24'h0, key});
            wr(`CTB_REG_CTRL, {31'h0, t != 1});
            build(u_phyA.q, 48 + $urandom % 13);
            build(u_phyB.q, 48);
            u_phyA.colAt = (t == 2) ? 20 : 9999;
            qA.delete();
            qB.delete();
            fork
                u_phyA.send();
                u_phyB.send();
            join
            while (teA === 1'b1 || teB === 1'b1) @(posedge clk);
            if (t < 2) begin
                chkFrame(qB, u_phyA.q, t != 1);
                chkFrame(qA, u_phyB.q, t != 1);
                chk(tEnB - u_phyA.tDa inside {[560:900]}, 1);
            end else
                chk(qB.size() < 64 + 8 * 20, 1);
            $display("test frame %0d done", t);
        end
        wr(`CTB_REG_ABORTS, 32'h0);
        rd(`CTB_REG_ABORTS, 32'h1, `CTB_RESP_OKAY);
        rd(`CTB_REG_FRAMES_A, 32'h3, `CTB_RESP_OKAY);
        complete_run();
    end
endmodule
`default_nettype wire

// ---- verif/ctb_xcvr.sv ----
// transceiver model of one ethernet port
`timescale 1ns/1ps
`default_nettype none
module ctb_xcvr #(
    parameter int OFS = 13
) (
    // line side toward the bridge
    output logic txClk,
    output logic rxClk,
    output logic rxData,
    output logic crsN,
    output logic col
);
    logic [7:0] q[$];
    int colAt = 9999;
    realtime tDa;
    initial begin
        rxClk = 1'b0;
        rxData = 1'b0;
        crsN = 1'b1;
        col = 1'b0;
        txClk = 1'b0;
        #OFS;
        forever #40 txClk = ~txClk;
    end
    task automatic nrz(input logic b);
        #40 rxClk = 1'b0;
        rxData = b;
        #40 rxClk = 1'b1;
    endtask
    task automatic send();
        #7 crsN = 1'b0;
        for (int i = 0; i < 62; i++)
            nrz(~i[0]);
        nrz(1'b1);
        nrz(1'b1);
        tDa = $realtime + 80;
        foreach (q[i])
            for (int j = 0; j < 8; j++) begin
                col = (i >= colAt);
                nrz(q[i][j]);
            end
        // carrier outlasts the last bit by a full bit period
        #80 crsN = 1'b1;
        col = 1'b0;
        rxData = ~rxData;
        rxClk = 1'b0;
    endtask
endmodule
`default_nettype wire
